/* File: common/scl_pkg.sv */
// shared constants and types of the serializer configuration latch port
package scl_pkg;
    localparam int NUM_CH = 4;
    localparam int CFG_ADDR_W = 4;
    localparam int CFG_DATA_W = 5;
    localparam int STAT_W = 9;
    // latch addresses on the configuration port
    localparam logic [3:0] LATCH_ADDR_CH_LAST = 4'h3;
    localparam logic [3:0] LATCH_ADDR_REINIT = 4'h4;
    localparam logic [3:0] LATCH_ADDR_GLOBAL_LATCH_WRITE_ENABLE = 4'h5;
    // apb byte offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_CFG = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0C;
    // status field positions
    localparam int ST_PHASE_ERR_LSB = 0;
    localparam int ST_BIST_PASS_LSB = 4;
    localparam int ST_CFG_WRITE = 8;
    // ctrl register field positions
    localparam int CTRL_REINIT_LSB = 0;
    localparam int CTRL_GLOBAL_LATCH_WRITE_ENABLE_LSB = 4;
    localparam int CTRL_RANGE_LSB = 8;
    // last count of the 511-character self-test pass period
    localparam logic [8:0] BIST_LAST = 9'h1FE;
    typedef struct packed {
        logic src_ref;
        logic rate_double;
        logic selftest_dis;
        logic secondary_en;
        logic primary_en;
    } scl_chan_cfg_type;
    typedef enum logic [1:0] {
        RANGE_LOW = 2'b00,
        RANGE_MID = 2'b01,
        RANGE_HIGH = 2'b11
    } scl_range_type;
    localparam scl_chan_cfg_type CHAN_CFG_RST = 5'h04;
    localparam logic [3:0] REINIT_RST = 4'hF;
    localparam logic [3:0] GLOBAL_LATCH_WRITE_ENABLE_RST = 4'hF;
    localparam logic [STAT_W-1:0] MASK_RST = 9'h000;
endpackage

/* File: src/scl_config_port.sv */
// configuration latch port with apb status, mask and readback registers
`timescale 1ns/100ps

// What this block does
// R1: half-rate reference samples channel inputs on both clock edges.
// R2: half-rate reference updates channel outputs on both clock edges.
// R3: three-level range select picks 195-400, 400-800 or 800-1500 MBd.
// R4: write strobe loads 5-bit data into the latch the 4-bit address selects.
// R5: reset returns every configuration latch to its initial value.
// R6: each channel has clock source, rate, self-test and buffer reset latches.
// R7: each channel has primary and secondary driver enable latches.
// R8: clock source 0 captures with input clock, 1 with reference clock.
// R9: clock output at reference rate for rate 0, double for rate 1.
// R10: writing 0 to buffer reset realigns phase and clears the phase-slip source of path error.
// R11: self-test enabled pulses error one character every 511 characters.
// R12: writes to unimplemented latch addresses change nothing.
module scl_config_port
    import scl_pkg::*;
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // configuration pins, asynchronous
    input wire logic latch_write_strobe_n,
    input wire logic [CFG_ADDR_W-1:0] cfg_addr,
    input wire logic [CFG_DATA_W-1:0] cfg_data,
    input wire logic [NUM_CH*2-1:0] serial_rate_range_select,
    // datapath side, synchronous to pclk
    input wire logic [NUM_CH-1:0] tx_char_tick,
    input wire logic [NUM_CH-1:0] phase_buffer_slip,
    // per-channel control outputs
    output scl_chan_cfg_type [NUM_CH-1:0] chan_cfg,
    output logic [NUM_CH-1:0] capture_on_reference,
    output logic [NUM_CH-1:0] dual_edge_sample,
    output logic [NUM_CH-1:0] dual_edge_present,
    output logic [NUM_CH-1:0] tx_clock_output_double,
    output logic [NUM_CH*2-1:0] pll_range,
    output logic [NUM_CH-1:0] phase_realign,
    output logic [NUM_CH-1:0] tx_path_error
);
    // pin synchronisers
    logic strobe_n_s1_q;
    logic strobe_n_s2_q;
    logic strobe_n_s3_q;
    logic [CFG_ADDR_W-1:0] addr_s1_q;
    logic [CFG_ADDR_W-1:0] addr_s2_q;
    logic [CFG_DATA_W-1:0] data_s1_q;
    logic [CFG_DATA_W-1:0] data_s2_q;
    logic [NUM_CH*2-1:0] range_s1_q;
    logic [NUM_CH*2-1:0] range_s2_q;
    logic latch_we;
    // latches
    scl_chan_cfg_type [NUM_CH-1:0] cfg_q;
    logic [NUM_CH-1:0] reinit_q;
    logic [NUM_CH-1:0] global_latch_write_enable_q;
    logic [NUM_CH-1:0] realign_q;
    // error and self-test
    logic [NUM_CH-1:0] phase_err_q;
    logic [NUM_CH-1:0] bist_pulse_q;
    logic [8:0] bist_cnt_q [NUM_CH];
    // apb registers
    logic [STAT_W-1:0] status_q;
    logic [STAT_W-1:0] mask_q;
    logic [STAT_W-1:0] status_set;
    logic apb_wr;
    logic apb_rd;
    logic addr_ok;
    logic [NUM_CH*2-1:0] pll_range_d;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_n_s1_q <= 1'b1;
            strobe_n_s2_q <= 1'b1;
            strobe_n_s3_q <= 1'b1;
            addr_s1_q <= '0;
            addr_s2_q <= '0;
            data_s1_q <= '0;
            data_s2_q <= '0;
            range_s1_q <= '0;
            range_s2_q <= '0;
        end else begin
            strobe_n_s1_q <= latch_write_strobe_n;
            strobe_n_s2_q <= strobe_n_s1_q;
            strobe_n_s3_q <= strobe_n_s2_q;
            addr_s1_q <= cfg_addr;
            addr_s2_q <= addr_s1_q;
            data_s1_q <= cfg_data;
            data_s2_q <= data_s1_q;
            range_s1_q <= serial_rate_range_select;
            range_s2_q <= range_s1_q;
        end
    end

    // write fires once on the strobe's falling edge
    assign latch_we = strobe_n_s3_q & ~strobe_n_s2_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reinit_q <= REINIT_RST; // R5
            global_latch_write_enable_q <= GLOBAL_LATCH_WRITE_ENABLE_RST; // R5
        end else if (latch_we) begin
            if (addr_s2_q == LATCH_ADDR_REINIT) begin
                reinit_q <= data_s2_q[NUM_CH-1:0]; // R4
            end
            if (addr_s2_q == LATCH_ADDR_GLOBAL_LATCH_WRITE_ENABLE) begin
                global_latch_write_enable_q <= data_s2_q[NUM_CH-1:0]; // R4
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            logic sel;
            assign sel = latch_we && (addr_s2_q == CFG_ADDR_W'(ch)); // R12

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg_q[ch] <= CHAN_CFG_RST; // R5
                end else if (sel && global_latch_write_enable_q[ch]) begin
                    cfg_q[ch] <= scl_chan_cfg_type'(data_s2_q); // R4 R6 R7
                end
            end

            // a write of 0 to the buffer reset latch re-centres the buffer
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    realign_q[ch] <= 1'b0;
                end else begin
                    realign_q[ch] <= latch_we && !data_s2_q[ch]
                        && (addr_s2_q == LATCH_ADDR_REINIT); // R10
                end
            end

            // slip sets, realign clears; a slip in the same cycle wins
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    phase_err_q[ch] <= 1'b0;
                end else if (phase_buffer_slip[ch]) begin
                    phase_err_q[ch] <= 1'b1;
                end else if (realign_q[ch]) begin
                    phase_err_q[ch] <= 1'b0; // R10
                end
            end

            // one-character pass pulse every 511 characters
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    bist_cnt_q[ch] <= '0;
                    bist_pulse_q[ch] <= 1'b0;
                end else if (cfg_q[ch].selftest_dis) begin
                    bist_cnt_q[ch] <= '0;
                    bist_pulse_q[ch] <= 1'b0;
                end else if (tx_char_tick[ch]) begin
                    bist_pulse_q[ch] <= (bist_cnt_q[ch] == BIST_LAST); // R11
                    if (bist_cnt_q[ch] == BIST_LAST) begin
                        bist_cnt_q[ch] <= '0; // R11
                    end else begin
                        bist_cnt_q[ch] <= bist_cnt_q[ch] + 9'h001;
                    end
                end
            end

            assign capture_on_reference[ch] = cfg_q[ch].src_ref; // R8
            assign tx_clock_output_double[ch] = cfg_q[ch].rate_double; // R9
            // a doubled output clock means the reference runs at half rate
            assign dual_edge_sample[ch] = cfg_q[ch].rate_double; // R1
            assign dual_edge_present[ch] = cfg_q[ch].rate_double; // R2
            assign phase_realign[ch] = realign_q[ch]; // R10
            assign tx_path_error[ch] = phase_err_q[ch] | bist_pulse_q[ch]
                | ~(cfg_q[ch].primary_en | cfg_q[ch].secondary_en); // R11
            assign status_set[ST_PHASE_ERR_LSB+ch] = phase_buffer_slip[ch];
            assign status_set[ST_BIST_PASS_LSB+ch] =
                tx_char_tick[ch] && !cfg_q[ch].selftest_dis
                && (bist_cnt_q[ch] == BIST_LAST);
        end
    endgenerate

    // the mid level is the only legal code with differing bits
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            unique case (range_s2_q[i*2 +: 2])
                RANGE_LOW: pll_range_d[i*2 +: 2] = RANGE_LOW; // R3
                RANGE_MID: pll_range_d[i*2 +: 2] = RANGE_MID; // R3
                RANGE_HIGH: pll_range_d[i*2 +: 2] = RANGE_HIGH; // R3
                default: pll_range_d[i*2 +: 2] = RANGE_MID;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_range <= '0;
        end else begin
            pll_range <= pll_range_d; // R3
        end
    end

    assign chan_cfg = cfg_q;
    assign status_set[ST_CFG_WRITE] = latch_we && (addr_s2_q <= LATCH_ADDR_GLOBAL_LATCH_WRITE_ENABLE);

    // apb slave, zero wait states
    assign pready = 1'b1;
    assign addr_ok = (paddr == REG_STATUS) || (paddr == REG_MASK)
        || (paddr == REG_CFG) || (paddr == REG_CTRL);
    assign pslverr = psel && penable && !addr_ok;
    assign apb_wr = psel && penable && pwrite && addr_ok;
    assign apb_rd = psel && !penable && !pwrite;

    // sticky events, write one to clear, set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
        end else if (apb_wr && paddr == REG_STATUS) begin
            status_q <= (status_q & ~pwdata[STAT_W-1:0]) | status_set;
        end else begin
            status_q <= status_q | status_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= MASK_RST;
        end else if (apb_wr && paddr == REG_MASK) begin
            mask_q <= pwdata[STAT_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & mask_q);
        end
    end

    // read data latched in the setup cycle, valid in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (apb_rd) begin
            unique case (paddr)
                REG_STATUS: prdata <= 32'(status_q);
                REG_MASK: prdata <= 32'(mask_q);
                REG_CFG: prdata <= 32'(cfg_q);
                REG_CTRL: prdata <= 32'({range_s2_q, global_latch_write_enable_q, reinit_q});
                default: prdata <= '0;
            endcase
        end
    end
endmodule // scl_config_port

/* File: test/scl_config_port_sva.sv */
// checker for the configuration latch port
`timescale 1ns/100ps
module scl_config_port_sva
    import scl_pkg::*;
(
    // clock, reset and apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    // configuration pins
    input wire logic latch_write_strobe_n,
    input wire logic [NUM_CH*2-1:0] serial_rate_range_select,
    // channel controls
    input wire scl_chan_cfg_type [NUM_CH-1:0] chan_cfg,
    input wire logic [NUM_CH-1:0] capture_on_reference,
    input wire logic [NUM_CH-1:0] dual_edge_sample,
    input wire logic [NUM_CH-1:0] dual_edge_present,
    input wire logic [NUM_CH-1:0] tx_clock_output_double,
    input wire logic [NUM_CH*2-1:0] pll_range,
    input wire logic [NUM_CH-1:0] tx_path_error
);
    logic [NUM_CH-1:0] rate_bits;
    logic [NUM_CH-1:0] src_bits;
    logic off0;
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            rate_bits[i] = chan_cfg[i].rate_double;
            src_bits[i] = chan_cfg[i].src_ref;
        end
        off0 = !chan_cfg[0].primary_en && !chan_cfg[0].secondary_en;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_idle; latch_write_strobe_n [*5]; endsequence
    sequence s_mid; (serial_rate_range_select[1:0] == 2'b10) [*5];
    endsequence
    property p_samp; dual_edge_sample == rate_bits; endproperty
    a_samp: assert property (p_samp) else $error("sample");
    property p_pres; dual_edge_present == rate_bits; endproperty
    a_pres: assert property (p_pres) else $error("present");
    property p_cap; capture_on_reference == src_bits; endproperty
    a_cap: assert property (p_cap) else $error("capture");
    property p_dbl; tx_clock_output_double == rate_bits; endproperty
    a_dbl: assert property (p_dbl) else $error("rate");
    property p_mid; s_mid |-> pll_range[1:0] == RANGE_MID; endproperty
    a_mid: assert property (p_mid) else $error("range");
    property p_idle; s_idle |-> $stable(chan_cfg); endproperty
    a_idle: assert property (p_idle) else $error("latch moved");
    property p_off; off0 [*2] |-> tx_path_error[0]; endproperty
    a_off: assert property (p_off) else $error("drivers off");
    property p_err; psel && penable && paddr > REG_CTRL |-> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("no slverr");
endmodule // scl_config_port_sva

bind scl_config_port scl_config_port_sva u_sva (.pclk, .presetn, .psel,
    .penable, .paddr, .pslverr, .latch_write_strobe_n,
    .serial_rate_range_select, .chan_cfg, .capture_on_reference,
    .dual_edge_sample, .dual_edge_present, .tx_clock_output_double,
    .pll_range, .tx_path_error);

/* File: test/scl_host_model.sv */
// host model driving the configuration latch pins
`timescale 1ns/100ps
module scl_host_model
    import scl_pkg::*;
(
    // clock
    input wire logic pclk,
    // configuration pins
    output logic latch_write_strobe_n,
    output logic [CFG_ADDR_W-1:0] cfg_addr,
    output logic [CFG_DATA_W-1:0] cfg_data
);
    // released pins float to their pull-up level
    initial begin
        latch_write_strobe_n = 1'b1;
        cfg_addr = 4'hF;
        cfg_data = 5'h1F;
    end
    task automatic write_latch(input logic [3:0] a, input logic [4:0] d);
        @(posedge pclk);
        cfg_addr <= a;
        cfg_data <= d;
        repeat (3) @(posedge pclk);
        latch_write_strobe_n <= 1'b0;
        repeat (4) @(posedge pclk);
        latch_write_strobe_n <= 1'b1;
        repeat (4) @(posedge pclk);
        cfg_addr <= 4'hF;
        cfg_data <= 5'h1F;
    endtask
endmodule // scl_host_model

/* File: test/scl_config_port_test.sv */
// self-checking bench for the configuration latch port
`timescale 1ns/100ps
module scl_config_port_test;
    import scl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, perr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic latch_write_strobe_n;
    logic [3:0] cfg_addr, phase_buffer_slip, capture_on_reference;
    logic [3:0] dual_edge_sample, dual_edge_present, tx_clock_output_double;
    logic [3:0] phase_realign, tx_path_error, tx_char_tick;
    logic [4:0] cfg_data;
    logic [7:0] serial_rate_range_select, pll_range;
    scl_chan_cfg_type [3:0] chan_cfg;
    logic [4:0] tbl [4] = '{5'h13, 5'h0B, 5'h1C, 5'h07};
    int num_errors = 0;
    int comparisons = 0;
    int rcnt = 0;
    scl_config_port uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq, .latch_write_strobe_n,
        .cfg_addr, .cfg_data, .serial_rate_range_select,
        .tx_char_tick, .phase_buffer_slip, .chan_cfg,
        .capture_on_reference, .dual_edge_sample, .dual_edge_present,
        .tx_clock_output_double, .pll_range, .phase_realign, .tx_path_error);
    scl_host_model host (.pclk, .latch_write_strobe_n, .cfg_addr, .cfg_data);
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (phase_realign[3] === 1'b1) rcnt <= rcnt + 1;
    end
    task automatic finish_test();
        if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            num_errors++;
            finish_test();
        end
        rdata = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask
    task automatic t_reset();
        rd(REG_CFG);
        check(rdata, 32'h00021084);
        rd(REG_CTRL);
        check(32'(rdata[7:0]), 32'hFF);
        rd(REG_STATUS);
        check(rdata, 32'h0);
        check(32'(tx_path_error), 32'hF);
    endtask
    task automatic t_chan();
        for (int i = 0; i < 4; i++) begin
            host.write_latch(4'(i), tbl[i]);
            check(32'(chan_cfg[i]), 32'(tbl[i]));
            check(32'(capture_on_reference[i]), 32'(tbl[i][4]));
            check(32'(tx_clock_output_double[i]), 32'(tbl[i][3]));
            check(32'(dual_edge_sample[i]), 32'(tbl[i][3]));
            check(32'(dual_edge_present[i]), 32'(tbl[i][3]));
        end
        rd(REG_STATUS);
        check(32'(rdata[8]), 32'h1);
        apb(1'b1, REG_MASK, 32'h100);
        repeat (2) @(negedge pclk);
        check(32'(irq), 32'h1);
        apb(1'b1, REG_STATUS, 32'h100);
        repeat (2) @(negedge pclk);
        check(32'(irq), 32'h0);
    endtask
    task automatic t_refuse();
        host.write_latch(4'h6, 5'h00);
        rd(REG_CFG);
        check(rdata, 32'({tbl[3], tbl[2], tbl[1], tbl[0]}));
        rd(REG_CTRL);
        check(32'(rdata[7:0]), 32'hFF);
        rd(REG_STATUS);
        check(rdata, 32'h0);
        host.write_latch(LATCH_ADDR_GLOBAL_LATCH_WRITE_ENABLE, 5'h0E);
        host.write_latch(4'h0, 5'h00);
        check(32'(chan_cfg[0]), 32'(tbl[0]));
        host.write_latch(LATCH_ADDR_GLOBAL_LATCH_WRITE_ENABLE, 5'h0F);
        rd(8'h10);
        check(32'(perr), 32'h1);
    endtask
    task automatic t_reinit();
        int r0;
        @(posedge pclk);
        phase_buffer_slip <= 4'h8;
        @(posedge pclk);
        phase_buffer_slip <= 4'h0;
        repeat (2) @(negedge pclk);
        check(32'(tx_path_error[3]), 32'h1);
        r0 = rcnt;
        host.write_latch(LATCH_ADDR_REINIT, 5'h07);
        @(negedge pclk);
        check(32'(rcnt - r0), 32'h1);
        check(32'(tx_path_error[3]), 32'h0);
    endtask
    task automatic t_bist();
        for (int i = 0; i < 511; i++) begin
            @(posedge pclk);
            tx_char_tick <= 4'h1;
            @(posedge pclk);
            tx_char_tick <= 4'h0;
            @(negedge pclk);
            check(32'(tx_path_error[0]), 32'(i == 510));
        end
        rd(REG_STATUS);
        check(32'(rdata[ST_BIST_PASS_LSB +: 4]), 32'h1);
        @(posedge pclk);
        tx_char_tick <= 4'h1;
        @(posedge pclk);
        tx_char_tick <= 4'h0;
        @(negedge pclk);
        check(32'(tx_path_error[0]), 32'h0);
    endtask
    task automatic t_range();
        logic [1:0] code [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
        logic [1:0] want [4] = '{2'b00, 2'b01, 2'b11, 2'b01};
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            serial_rate_range_select <= {4{code[i]}};
            repeat (6) @(negedge pclk);
            check(32'(pll_range), 32'({4{want[i]}}));
            rd(REG_CTRL);
            check(32'(rdata[CTRL_RANGE_LSB +: 8]), 32'({4{code[i]}}));
        end
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        phase_buffer_slip = 4'h0;
        tx_char_tick = 4'h0;
        serial_rate_range_select = 8'h00;
        do_reset();
        t_reset();
        t_chan();
        t_refuse();
        t_reinit();
        t_bist();
        t_range();
        do_reset();
        t_reset();
        finish_test();
    end
endmodule // scl_config_port_test
